// ===== aer_pkg.sv
// Purpose: Constants for the error report header and status bank
// Assumes: APB with 32-bit data, byte addresses as printed
// Notes:   Shared by the register bank and its bench
package aer_pkg;
   localparam logic [11:0] OFS_HEADER     = 12'h100;
   localparam logic [11:0] OFS_UNC_STATUS = 12'h104;
   localparam logic [11:0] OFS_MASK       = 12'h108;
   localparam logic [15:0] CAP_ID_VALUE   = 16'h0001;
   localparam logic [3:0]  CAP_VER_VALUE  = 4'h1;
   localparam logic [11:0] NXT_PTR_RESET  = 12'h000;
   localparam int          CAP_ID_LSB     = 0;
   localparam int          CAP_VER_LSB    = 16;
   localparam int          NXT_PTR_LSB    = 20;
   localparam int          BIT_LEGACY     = 0;
   localparam int          BIT_LINK_PROT  = 4;
   localparam int          BIT_SURPRISE   = 5;
   localparam int          BIT_POISONED   = 12;
   localparam int          BIT_FLOW_CTRL  = 13;
   localparam int          BIT_CPL_TMO    = 14;
   localparam int          BIT_CPL_ABORT  = 15;
   localparam int          BIT_UNEXP_CPL  = 16;
   localparam int          BIT_RX_OVFL    = 17;
   localparam int          BIT_MALFORMED  = 18;
   localparam int          BIT_E2E_CRC    = 19;
   localparam int          BIT_UNSUP_REQ  = 20;
   localparam int          BIT_ACS_VIOL   = 21;
   localparam int          BIT_INT_ERR    = 22;
   localparam int          BIT_MC_BLOCK   = 23;
   // Writable-by-one bits, hardware-settable except legacy bit 0; others read zero
   localparam logic [31:0] STATUS_IMPL    = 32'h00ff_3031;
   localparam logic [31:0] MASK_IMPL      = 32'h00ff_3031;
   localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
endpackage

// ===== aer_regs.sv
// Purpose: Error report capability header and uncorrectable status bank
// Assumes: APB slave, zero wait states, pslverr on unmapped addresses
// Notes:   Sticky flags are cleared only by power-on reset or write-one
//
// How it works
// - Header identifier field reads fixed one
// - Header version field reads fixed one
// - Next pointer writable unless locked; zero ends
// - Link protocol error sets bit 4
// - Surprise down sets bit 5 if capable
// - Poisoned packet sets bit 12
// - Flow control error sets bit 13
// - Completion timeout bit always zero
// - Completer abort zero; access violations separate
// - Unexpected completion sets bit 16
// - Receive overflow sets bit 17
// - Malformed packet sets bit 18
// - End-to-end CRC error sets bit 19
// - Unsupported request sets bit 20
// - Access control violation sets bit 21
// - Internal error sets bit 22
// - Blocked multicast packet sets bit 23
// - Legacy bit clearable only; reserved read zero
// - Mask gates reporting, never status setting
module aer_regs (
   input  wire logic        pclk,                           // APB clock, 200 MHz
   input  wire logic        presetn,                        // Power-on reset, active low
   input  wire logic        port_reset_n,                   // Port (non-power-on) reset, active low
   input  wire logic        psel,                           // APB select
   input  wire logic        penable,                        // APB access phase
   input  wire logic        pwrite,                         // APB write
   input  wire logic [11:0] paddr,                          // APB byte address
   input  wire logic [31:0] pwdata,                         // APB write data
   input  wire logic [3:0]  pstrb,                          // APB byte strobes
   output logic      [31:0] prdata,                         // APB read data
   output logic             pready,                         // APB ready
   output logic             pslverr,                        // APB error, unmapped
   input  wire logic        next_ptr_lock,                  // Freeze next pointer
   input  wire logic        link_protocol_error,            // Event pulses from port logic
   input  wire logic        surprise_down_error,            // Surprise down detected
   input  wire logic        surprise_down_report_capable,   // Link capability bit
   input  wire logic        poisoned_tlp,                   // Poisoned packet received
   input  wire logic        flow_control_error,             // Flow control protocol error
   input  wire logic        unexpected_completion,          // Unexpected completion
   input  wire logic        receive_overflow,               // Receive buffer overflow
   input  wire logic        malformed_tlp,                  // Malformed packet
   input  wire logic        e2e_crc_error,                  // End-to-end CRC error
   input  wire logic        unsupported_request,            // Unsupported request
   input  wire logic        access_control_violation,       // Access control violation
   input  wire logic        internal_error,                 // Uncorrectable internal error
   input  wire logic        multicast_blocked,              // Multicast packet blocked
   output logic      [31:0] status_flags,                   // Status register copy
   output logic      [31:0] unmasked_errors                 // Flags passing the mask
);

   logic [11:0] next_capability_pointer_ff;
   logic [31:0] status_ff;
   logic [31:0] mask_ff;
   logic [31:0] error_set;
   logic [31:0] write_clear;
   logic [31:0] nxt_status;
   logic [31:0] nxt_prdata;
   logic        nxt_pslverr;
   logic        wr_access;
   logic        rd_access;
   logic        addr_hit;

   // Expand byte strobes into a bit mask
   function automatic logic [31:0] strb_bits(input logic [3:0] s);
      strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // Address decode for the mapped words
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == aer_pkg::OFS_HEADER) || (a == aer_pkg::OFS_UNC_STATUS)
                  || (a == aer_pkg::OFS_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake
   assign pready    = 1'b1;
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign addr_hit  = is_mapped(paddr);

   ////////////////////////////////////////////////////////////////////////////
   // Event collection into status bit positions
   always_comb begin
      error_set = 32'h0000_0000;
      error_set[aer_pkg::BIT_LINK_PROT] = link_protocol_error;
      error_set[aer_pkg::BIT_SURPRISE]  = surprise_down_error && surprise_down_report_capable;
      error_set[aer_pkg::BIT_POISONED]  = poisoned_tlp;
      error_set[aer_pkg::BIT_FLOW_CTRL] = flow_control_error;
      error_set[aer_pkg::BIT_UNEXP_CPL] = unexpected_completion;
      error_set[aer_pkg::BIT_RX_OVFL]   = receive_overflow;
      error_set[aer_pkg::BIT_MALFORMED] = malformed_tlp;
      error_set[aer_pkg::BIT_E2E_CRC]   = e2e_crc_error;
      error_set[aer_pkg::BIT_UNSUP_REQ] = unsupported_request;
      error_set[aer_pkg::BIT_ACS_VIOL]  = access_control_violation;
      error_set[aer_pkg::BIT_INT_ERR]   = internal_error;
      error_set[aer_pkg::BIT_MC_BLOCK]  = multicast_blocked;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status: set beats clear, port reset has no effect
   always_comb begin
      write_clear = 32'h0000_0000;
      if (wr_access && paddr == aer_pkg::OFS_UNC_STATUS) begin
         write_clear = pwdata & strb_bits(pstrb);
      end
      nxt_status = ((status_ff & ~write_clear) | error_set) & aer_pkg::STATUS_IMPL;
   end

   // Status register, only power-on reset or write-one clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= aer_pkg::STATUS_RESET;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Mask register, sticky like the status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= aer_pkg::MASK_RESET;
      end else if (wr_access && paddr == aer_pkg::OFS_MASK) begin
         mask_ff <= ((mask_ff & ~strb_bits(pstrb)) | (pwdata & strb_bits(pstrb)))
                    & aer_pkg::MASK_IMPL;
      end
   end

   // Next pointer, writable while unlocked, cleared by port reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_capability_pointer_ff <= aer_pkg::NXT_PTR_RESET;
      end else if (!port_reset_n) begin
         next_capability_pointer_ff <= aer_pkg::NXT_PTR_RESET;
      end else if (wr_access && paddr == aer_pkg::OFS_HEADER && !next_ptr_lock) begin
         if (pstrb[2]) begin
            next_capability_pointer_ff[3:0] <= pwdata[23:20];
         end
         if (pstrb[3]) begin
            next_capability_pointer_ff[11:4] <= pwdata[31:24];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data and error, captured in the setup cycle
   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = !addr_hit;  // Unmapped words answer with an error
      case (paddr)
         aer_pkg::OFS_HEADER: begin
            nxt_prdata = {next_capability_pointer_ff, aer_pkg::CAP_VER_VALUE,
                          aer_pkg::CAP_ID_VALUE};
         end
         aer_pkg::OFS_UNC_STATUS: begin
            nxt_prdata = status_ff;
         end
         aer_pkg::OFS_MASK: begin
            nxt_prdata = mask_ff;
         end
         default: begin
            nxt_prdata = 32'h0000_0000;
         end
      endcase
   end

   // Registered read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_access) begin
         prdata <= nxt_prdata;
      end
   end

   // Registered slave error for unmapped words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= nxt_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status views for the logging logic
   assign status_flags    = status_ff;
   assign unmasked_errors = status_ff & ~mask_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Header constants read back
   chk_hdr_const: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == aer_pkg::OFS_HEADER) |=>
      (prdata[19:0] == {aer_pkg::CAP_VER_VALUE, aer_pkg::CAP_ID_VALUE}))
      else $error("header constant fields wrong");

   // Version field alone
   chk_ver_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == aer_pkg::OFS_HEADER) |=>
      (prdata[19:16] == aer_pkg::CAP_VER_VALUE))
      else $error("version field wrong");

   // Lock freezes the pointer
   chk_ptr_lock: assert property (@(posedge pclk) disable iff (!presetn)
      (next_ptr_lock && port_reset_n) |=> $stable(next_capability_pointer_ff))
      else $error("locked pointer changed");

   // Link protocol event sets its flag
   chk_link_set: assert property (@(posedge pclk) disable iff (!presetn)
      link_protocol_error |=> status_ff[aer_pkg::BIT_LINK_PROT])
      else $error("link protocol flag not set");

   // Surprise down needs the capability
   chk_sd_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (!status_ff[aer_pkg::BIT_SURPRISE] && !surprise_down_report_capable) |=>
      !status_ff[aer_pkg::BIT_SURPRISE])
      else $error("surprise flag set without capability");

   // Unused status bits never set
   chk_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
      (status_ff & ~aer_pkg::STATUS_IMPL) == 32'h0000_0000)
      else $error("hardwired status bit set");

   // Access violation is not an abort
   chk_acs_only: assert property (@(posedge pclk) disable iff (!presetn)
      access_control_violation |=> status_ff[aer_pkg::BIT_ACS_VIOL] && !status_ff[aer_pkg::BIT_CPL_ABORT])
      else $error("access violation logged wrongly");

   // Blocked multicast sets its flag
   chk_mc_set: assert property (@(posedge pclk) disable iff (!presetn)
      multicast_blocked |=> status_ff[aer_pkg::BIT_MC_BLOCK])
      else $error("multicast flag not set");

   // Legacy flag stays clear
   chk_legacy_never: assert property (@(posedge pclk) disable iff (!presetn)
      !status_ff[aer_pkg::BIT_LEGACY])
      else $error("legacy flag set");

   // Flag held while no write comes
   chk_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (status_ff[aer_pkg::BIT_POISONED] && !wr_access) |=> status_ff[aer_pkg::BIT_POISONED])
      else $error("sticky flag lost");

   // Event beats a same-cycle clear
   chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (flow_control_error && wr_access && paddr == aer_pkg::OFS_UNC_STATUS) |=>
      status_ff[aer_pkg::BIT_FLOW_CTRL])
      else $error("set lost to clear");

   // Write one clears malformed flag
   chk_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_access && paddr == aer_pkg::OFS_UNC_STATUS && pstrb[2] && pwdata[aer_pkg::BIT_MALFORMED]
       && !malformed_tlp) |=> !status_ff[aer_pkg::BIT_MALFORMED])
      else $error("write one did not clear");

   // Mask leaves the status alone
   chk_mask_nogate: assert property (@(posedge pclk) disable iff (!presetn)
      (unexpected_completion && mask_ff[aer_pkg::BIT_UNEXP_CPL]) |=>
      status_ff[aer_pkg::BIT_UNEXP_CPL] && !unmasked_errors[aer_pkg::BIT_UNEXP_CPL])
      else $error("mask affected status");

   // Capable surprise down sets its flag
   chk_sd_set: assert property (@(posedge pclk) disable iff (!presetn)
      (surprise_down_error && surprise_down_report_capable) |=> status_ff[aer_pkg::BIT_SURPRISE])
      else $error("surprise flag not set");

   // Poisoned packet sets its flag
   chk_poison_set: assert property (@(posedge pclk) disable iff (!presetn)
      poisoned_tlp |=> status_ff[aer_pkg::BIT_POISONED])
      else $error("poisoned flag not set");

   // Flow control error sets its flag
   chk_fc_set: assert property (@(posedge pclk) disable iff (!presetn)
      flow_control_error |=> status_ff[aer_pkg::BIT_FLOW_CTRL])
      else $error("flow control flag not set");

   // Completion timeout reads zero
   chk_tmo_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == aer_pkg::OFS_UNC_STATUS) |=> !prdata[aer_pkg::BIT_CPL_TMO])
      else $error("timeout bit read as one");

   // Completer abort reads zero
   chk_abort_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == aer_pkg::OFS_UNC_STATUS) |=> !prdata[aer_pkg::BIT_CPL_ABORT])
      else $error("abort bit read as one");

   // Unexpected completion sets its flag
   chk_unexp_set: assert property (@(posedge pclk) disable iff (!presetn)
      unexpected_completion |=> status_ff[aer_pkg::BIT_UNEXP_CPL])
      else $error("unexpected completion flag not set");

   // Receive overflow sets its flag
   chk_ovfl_set: assert property (@(posedge pclk) disable iff (!presetn)
      receive_overflow |=> status_ff[aer_pkg::BIT_RX_OVFL])
      else $error("overflow flag not set");

   // Malformed packet sets its flag
   chk_malf_set: assert property (@(posedge pclk) disable iff (!presetn)
      malformed_tlp |=> status_ff[aer_pkg::BIT_MALFORMED])
      else $error("malformed flag not set");

   // End-to-end CRC error sets its flag
   chk_crc_set: assert property (@(posedge pclk) disable iff (!presetn)
      e2e_crc_error |=> status_ff[aer_pkg::BIT_E2E_CRC])
      else $error("crc flag not set");

   // Unsupported request sets its flag
   chk_ur_set: assert property (@(posedge pclk) disable iff (!presetn)
      unsupported_request |=> status_ff[aer_pkg::BIT_UNSUP_REQ])
      else $error("unsupported request flag not set");

   // Internal error sets its flag
   chk_int_set: assert property (@(posedge pclk) disable iff (!presetn)
      internal_error |=> status_ff[aer_pkg::BIT_INT_ERR])
      else $error("internal error flag not set");

   // Reserved status bits read zero
   chk_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == aer_pkg::OFS_UNC_STATUS) |=>
      ((prdata & ~aer_pkg::STATUS_IMPL) == 32'h0000_0000))
      else $error("reserved status bit read as one");

   // Port reset keeps every set flag
   chk_port_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (!port_reset_n && !wr_access) |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
      else $error("port reset cleared a flag");

   // Port reset returns pointer to zero
   chk_ptr_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !port_reset_n |=> (next_capability_pointer_ff == aer_pkg::NXT_PTR_RESET))
      else $error("pointer not cleared by port reset");

   // Write one clears link flag
   chk_w1c_link: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_LINK_PROT] && !link_protocol_error) |=> !status_ff[aer_pkg::BIT_LINK_PROT])
      else $error("link flag not cleared");

   // Write one clears poisoned flag
   chk_w1c_poison: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_POISONED] && !poisoned_tlp) |=> !status_ff[aer_pkg::BIT_POISONED])
      else $error("poisoned flag not cleared");

   // Write one clears unexpected completion flag
   chk_w1c_unexp: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_UNEXP_CPL] && !unexpected_completion) |=> !status_ff[aer_pkg::BIT_UNEXP_CPL])
      else $error("unexpected completion flag not cleared");

   // Write one clears overflow flag
   chk_w1c_ovfl: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_RX_OVFL] && !receive_overflow) |=> !status_ff[aer_pkg::BIT_RX_OVFL])
      else $error("overflow flag not cleared");

   // Write one clears crc flag
   chk_w1c_crc: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_E2E_CRC] && !e2e_crc_error) |=> !status_ff[aer_pkg::BIT_E2E_CRC])
      else $error("crc flag not cleared");

   // Write one clears unsupported request flag
   chk_w1c_ur: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_UNSUP_REQ] && !unsupported_request) |=> !status_ff[aer_pkg::BIT_UNSUP_REQ])
      else $error("unsupported request flag not cleared");

   // Write one clears access violation flag
   chk_w1c_acs: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_ACS_VIOL] && !access_control_violation) |=> !status_ff[aer_pkg::BIT_ACS_VIOL])
      else $error("access violation flag not cleared");

   // Write one clears multicast flag
   chk_w1c_mc: assert property (@(posedge pclk) disable iff (!presetn)
      (write_clear[aer_pkg::BIT_MC_BLOCK] && !multicast_blocked) |=> !status_ff[aer_pkg::BIT_MC_BLOCK])
      else $error("multicast flag not cleared");

   // Main scenarios reached
   cov_err_set: cover property (@(posedge pclk) disable iff (!presetn) $rose(status_ff[aer_pkg::BIT_UNSUP_REQ]));
   cov_w1c: cover property (@(posedge pclk) disable iff (!presetn) $fell(status_ff[aer_pkg::BIT_E2E_CRC]));
   cov_ptr_wr: cover property (@(posedge pclk) disable iff (!presetn) $changed(next_capability_pointer_ff));
   cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr && penable);
   cov_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
      flow_control_error && write_clear[aer_pkg::BIT_FLOW_CTRL]);
endmodule

// ===== test_aer_regs.sv
// Purpose: Self-checking bench for the error report header and status bank
// Assumes: Zero wait APB slave; event inputs sampled at each rising edge
// Notes:   Mask register at 0x108 is used to show that status is never gated
module test_aer_regs;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] HDR = aer_pkg::OFS_HEADER;
   localparam logic [11:0] STA = aer_pkg::OFS_UNC_STATUS;
   localparam logic [31:0] ALL = 32'h00ff_3030;
   logic        pclk = 1'b0, presetn = 1'b0, port_reset_n = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, next_ptr_lock = 1'b0, cap = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000, ev = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, status_flags, unmasked_errors;
   logic [3:0]  pstrb = 4'h0;
   int          err_count = 0, samples_checked = 0, cyc = 0;
   int          bitpos [12] = '{4, 5, 12, 13, 16, 17, 18, 19, 20, 21, 22, 23};

   ////////////////////////////////////////////////////////////////////////////////
   // Device under test, events on one vector
   aer_regs aer_regs_i (.pclk(pclk), .presetn(presetn), .port_reset_n(port_reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .next_ptr_lock(next_ptr_lock), .link_protocol_error(ev[0]),
      .surprise_down_error(ev[1]), .surprise_down_report_capable(cap), .poisoned_tlp(ev[2]),
      .flow_control_error(ev[3]), .unexpected_completion(ev[4]), .receive_overflow(ev[5]),
      .malformed_tlp(ev[6]), .e2e_crc_error(ev[7]), .unsupported_request(ev[8]),
      .access_control_violation(ev[9]), .internal_error(ev[10]), .multicast_blocked(ev[11]),
      .status_flags(status_flags), .unmasked_errors(unmasked_errors));

   // Clock and hang guard
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, bus and stimulus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, s, rd, er);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0000_0000, 4'h0, rd, er);
      chk(rd, exp, what);
   endtask
   task automatic pulse(input logic [11:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 12'h000;
      #1;
   endtask
   task automatic port_rst();
      @(posedge pclk);
      port_reset_n <= 1'b0;
      repeat (2) @(posedge pclk);
      port_reset_n <= 1'b1;
   endtask
   function automatic logic [31:0] hdr_val(input logic [11:0] ptr);
      return {ptr, aer_pkg::CAP_VER_VALUE, aer_pkg::CAP_ID_VALUE};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_header();
      rd_chk(HDR, hdr_val(12'h000), "header at reset");
      wr(HDR, 32'hffff_ffff, 4'hf);
      rd_chk(HDR, hdr_val(12'hfff), "header after write");
      @(posedge pclk);
      next_ptr_lock <= 1'b1;
      wr(HDR, 32'h0000_0000, 4'hf);
      rd_chk(HDR, hdr_val(12'hfff), "locked pointer");
      @(posedge pclk);
      next_ptr_lock <= 1'b0;
      wr(HDR, 32'h0000_0000, 4'h4);
      rd_chk(HDR, hdr_val(12'hff0), "pointer byte strobe");
      port_rst();
      rd_chk(HDR, hdr_val(12'h000), "pointer after port reset");
   endtask
   task automatic t_events();
      rd_chk(STA, 32'h0000_0000, "status at reset");
      pulse(12'h002);
      chk(status_flags, 32'h0000_0000, "surprise down not capable");
      @(posedge pclk);
      cap <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         pulse(12'h001 << i);
         chk(status_flags, 32'h1 << bitpos[i], "single event flag");
         rd_chk(STA, 32'h1 << bitpos[i], "single event read");
         wr(STA, 32'h1 << bitpos[i], 4'hf);
         rd_chk(STA, 32'h0000_0000, "write one clears");
      end
   endtask
   task automatic t_set_wins();
      pulse(12'h048);                                  // Flow control and malformed
      fork
         wr(STA, 32'hffff_ffff, 4'hf);
         begin
            @(posedge pclk);
            pulse(12'h008);                            // Lands on the access edge
         end
      join
      chk(status_flags, 32'h1 << aer_pkg::BIT_FLOW_CTRL, "event beats same-cycle clear");
   endtask
   task automatic t_sticky_mask();
      logic [31:0] rd;
      logic        er;
      pulse(12'hfff);
      chk(status_flags, ALL, "all events");
      port_rst();
      chk(status_flags, ALL, "status after port reset");
      wr(aer_pkg::OFS_MASK, aer_pkg::MASK_IMPL, 4'hf);
      wr(STA, 32'hffff_ffff, 4'hf);
      pulse(12'hfff);
      chk(status_flags, ALL, "masked events still set");
      chk(unmasked_errors, 32'h0000_0000, "mask hides all");
      wr(aer_pkg::OFS_MASK, 32'h0000_0000, 4'hf);
      #1;
      chk(unmasked_errors, ALL, "unmasked after clear of mask");
      wr(STA, 32'hffff_ffff, 4'hf);
      rd_chk(STA, 32'h0000_0000, "reserved stay zero");
      pulse(12'hfff);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk(status_flags, 32'h0000_0000, "status after power-on reset");
      apb(1'b0, 12'h10c, 32'h0000_0000, 4'h0, rd, er);
      chk({rd[31:1], er}, 32'h0000_0001, "unmapped read");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and main sequence
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_header();
      t_events();
      t_set_wins();
      t_sticky_mask();
      print_verdict();
   end
endmodule
